/* File: hdl/flir_pkg.sv */
// Package with levels, line indices and modes of the four-level interrupt request block.
package flir_pkg;

  // ****************************************
  // Request line indices
  // ****************************************
  localparam int unsigned LINE_L4 = 0;
  localparam int unsigned LINE_L5 = 1;
  localparam int unsigned LINE_L6 = 2;
  localparam int unsigned LINE_L7 = 3;
  localparam int unsigned NUM_LINES = 4;

  // ****************************************
  // Level codes
  // ****************************************
  localparam logic [1:0] LVL_4 = 2'h0;
  localparam logic [1:0] LVL_5 = 2'h1;
  localparam logic [1:0] LVL_6 = 2'h2;
  localparam logic [1:0] LVL_7 = 2'h3;

  // ****************************************
  // Methods and states
  // ****************************************
  localparam logic MODE_POS_DEP   = 1'h0;
  localparam logic MODE_POS_INDEP = 1'h1;

  typedef enum logic [2:0] {
    ST_IDLE    = 3'h1,
    ST_REQUEST = 3'h2,
    ST_SERVICE = 3'h4
  } flir_state_e;

  localparam logic [3:0] LINES_NONE = 4'h0;

endpackage

/* File: hdl/flir_level_map.sv */
// Level to asserted-lines and monitored-lines decoder.
`timescale 1ns/1ns
module flir_level_map (
  // Configuration
  input  wire logic [1:0] level,
  input  wire logic       mode,
  // Decoded masks
  output logic [3:0]      assert_mask,
  output logic [3:0]      monitor_mask
);

  always_comb begin
    assert_mask  = flir_pkg::LINES_NONE;
    monitor_mask = flir_pkg::LINES_NONE;
    if (mode == flir_pkg::MODE_POS_DEP) begin
      assert_mask[level] = 1'b1;
    end else begin
      assert_mask[flir_pkg::LINE_L4] = 1'b1;
      case (level)
        flir_pkg::LVL_4: begin
          monitor_mask[flir_pkg::LINE_L5] = 1'b1;
          monitor_mask[flir_pkg::LINE_L6] = 1'b1;
        end
        flir_pkg::LVL_5: begin
          assert_mask[flir_pkg::LINE_L5]  = 1'b1;
          monitor_mask[flir_pkg::LINE_L6] = 1'b1;
        end
        flir_pkg::LVL_6: begin
          assert_mask[flir_pkg::LINE_L6]  = 1'b1;
          monitor_mask[flir_pkg::LINE_L7] = 1'b1;
        end
        flir_pkg::LVL_7: begin
          assert_mask[flir_pkg::LINE_L6] = 1'b1;
          assert_mask[flir_pkg::LINE_L7] = 1'b1;
        end
        default: begin
          assert_mask = flir_pkg::LINES_NONE;
        end
      endcase
    end
  end

endmodule // flir_level_map

/* File: hdl/flir_request.sv */
// Interrupt request and grant chain logic of one bus I/O module.
`timescale 1ns/1ns
module flir_request (
  // Clock and reset
  input  wire logic       mclk,
  input  wire logic       rst,
  // Configuration
  input  wire logic [1:0] level,
  input  wire logic       mode,
  // Device side
  input  wire logic       irq_event,
  input  wire logic       service_done,
  output logic            granted,
  // Bus request lines, index 0 is level 4
  input  wire logic [3:0] level_request_line_in,
  output logic [3:0]      level_request_line_out,
  // Grant chain
  input  wire logic       grant_chain_in,
  output logic            grant_chain_out
);

  // ****************************************
  // Decoding
  // ****************************************
  logic [3:0] assert_mask;
  logic [3:0] monitor_mask;

  flir_level_map u_map (
    .level        (level),
    .mode         (mode),
    .assert_mask  (assert_mask),
    .monitor_mask (monitor_mask)
  );

  // The decoder and the line ports are built for exactly four request lines.
  if ($bits(level_request_line_out) != flir_pkg::NUM_LINES) begin : g_line_count
    $error("Request line ports do not match the line count.");
  end

  // ****************************************
  // Request state machine
  // ****************************************
  flir_pkg::flir_state_e state_q, state_d;
  logic [3:0]            lines_q, lines_d;
  logic                  pass_q,  pass_d;
  logic                  grant_q, grant_d;
  logic                  higher;

  always_comb begin
    higher  = |(level_request_line_in & monitor_mask);
    state_d = state_q;
    lines_d = flir_pkg::LINES_NONE;
    pass_d  = 1'b0;
    grant_d = 1'b0;
    case (state_q)
      flir_pkg::ST_IDLE: begin
        pass_d = grant_chain_in;
        if (irq_event) begin
          state_d = flir_pkg::ST_REQUEST;
        end
      end
      flir_pkg::ST_REQUEST: begin
        lines_d = assert_mask;
        if (grant_chain_in) begin
          if (mode == flir_pkg::MODE_POS_INDEP && higher) begin
            pass_d = 1'b1;
          end else begin
            state_d = flir_pkg::ST_SERVICE;
            lines_d = flir_pkg::LINES_NONE;
            grant_d = 1'b1;
          end
        end
      end
      flir_pkg::ST_SERVICE: begin
        if (service_done) begin
          state_d = flir_pkg::ST_IDLE;
        end
      end
      default: begin
        state_d = flir_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      state_q <= flir_pkg::ST_IDLE;
      lines_q <= flir_pkg::LINES_NONE;
      pass_q  <= 1'b0;
      grant_q <= 1'b0;
    end else begin
      state_q <= state_d;
      lines_q <= lines_d;
      pass_q  <= pass_d;
      grant_q <= grant_d;
    end
  end

  assign level_request_line_out = lines_q;
  assign grant_chain_out        = pass_q;
  assign granted                = grant_q;

  // ****************************************
  // Checks
  // ****************************************
  // Single line bits, built from the line indices and not from the decoder.
  localparam logic [3:0] BIT_L4 = 4'h1 << flir_pkg::LINE_L4;
  localparam logic [3:0] BIT_L5 = 4'h1 << flir_pkg::LINE_L5;
  localparam logic [3:0] BIT_L6 = 4'h1 << flir_pkg::LINE_L6;
  localparam logic [3:0] BIT_L7 = 4'h1 << flir_pkg::LINE_L7;

  pass_idle_a: assert property (@(posedge mclk) disable iff (rst)
    state_q == flir_pkg::ST_IDLE && grant_chain_in |=> grant_chain_out)
    else $error("Idle module did not pass grant.");

  keep_dep_a: assert property (@(posedge mclk) disable iff (rst)
    state_q == flir_pkg::ST_REQUEST && mode == flir_pkg::MODE_POS_DEP && grant_chain_in
    |=> !grant_chain_out && granted)
    else $error("Position-dependent module passed grant while requesting.");

  pass_higher_a: assert property (@(posedge mclk) disable iff (rst)
    state_q == flir_pkg::ST_REQUEST && mode == flir_pkg::MODE_POS_INDEP && grant_chain_in
    && higher |=> grant_chain_out && !granted)
    else $error("Grant not forwarded despite higher request.");

  keep_lower_a: assert property (@(posedge mclk) disable iff (rst)
    state_q == flir_pkg::ST_REQUEST && grant_chain_in && !higher
    |=> !grant_chain_out && state_q == flir_pkg::ST_SERVICE)
    else $error("Grant not kept without higher request.");

  line4_a: assert property (@(posedge mclk) disable iff (rst)
    state_q == flir_pkg::ST_REQUEST && mode == flir_pkg::MODE_POS_INDEP
    |=> (state_q != flir_pkg::ST_REQUEST) || level_request_line_out[flir_pkg::LINE_L4])
    else $error("Level 4 line not asserted.");

  own_line_a: assert property (@(posedge mclk) disable iff (rst)
    mode == flir_pkg::MODE_POS_DEP && level_request_line_out != flir_pkg::LINES_NONE
    |-> $onehot(level_request_line_out) && level_request_line_out[$past(level)])
    else $error("Position-dependent set wrong line.");

  set_l7_a: assert property (@(posedge mclk) disable iff (rst)
    mode == flir_pkg::MODE_POS_INDEP && level == flir_pkg::LVL_7
    && $stable(level) && $stable(mode) && level_request_line_out != flir_pkg::LINES_NONE
    |-> level_request_line_out == (BIT_L4 | BIT_L6 | BIT_L7))
    else $error("Level 7 line set wrong.");

  hold_lines_a: assert property (@(posedge mclk) disable iff (rst)
    state_q == flir_pkg::ST_REQUEST && !grant_chain_in && $stable(level) && $stable(mode)
    ##1 state_q == flir_pkg::ST_REQUEST |-> level_request_line_out == assert_mask)
    else $error("Request lines dropped before grant kept.");

  release_a: assert property (@(posedge mclk) disable iff (rst)
    state_q == flir_pkg::ST_SERVICE |-> level_request_line_out == flir_pkg::LINES_NONE)
    else $error("Request lines held during service.");

  set_l4_a: assert property (@(posedge mclk) disable iff (rst)
    mode == flir_pkg::MODE_POS_INDEP && level == flir_pkg::LVL_4
    && $stable(level) && $stable(mode) && level_request_line_out != flir_pkg::LINES_NONE
    |-> level_request_line_out == BIT_L4)
    else $error("Level 4 line set wrong.");

  set_l5_a: assert property (@(posedge mclk) disable iff (rst)
    mode == flir_pkg::MODE_POS_INDEP && level == flir_pkg::LVL_5
    && $stable(level) && $stable(mode) && level_request_line_out != flir_pkg::LINES_NONE
    |-> level_request_line_out == (BIT_L4 | BIT_L5))
    else $error("Level 5 line set wrong.");

  set_l6_a: assert property (@(posedge mclk) disable iff (rst)
    mode == flir_pkg::MODE_POS_INDEP && level == flir_pkg::LVL_6
    && $stable(level) && $stable(mode) && level_request_line_out != flir_pkg::LINES_NONE
    |-> level_request_line_out == (BIT_L4 | BIT_L6))
    else $error("Level 6 line set wrong.");

  l4_sees_l5_a: assert property (@(posedge mclk) disable iff (rst)
    state_q == flir_pkg::ST_REQUEST && mode == flir_pkg::MODE_POS_INDEP
    && level == flir_pkg::LVL_4 && grant_chain_in && level_request_line_in[flir_pkg::LINE_L5]
    |=> grant_chain_out && !granted)
    else $error("Level 4 module kept grant over level 5 request.");

  l4_sees_l6_a: assert property (@(posedge mclk) disable iff (rst)
    state_q == flir_pkg::ST_REQUEST && mode == flir_pkg::MODE_POS_INDEP
    && level == flir_pkg::LVL_4 && grant_chain_in && level_request_line_in[flir_pkg::LINE_L6]
    |=> grant_chain_out && !granted)
    else $error("Level 4 module kept grant over level 6 request.");

  l6_sees_l7_a: assert property (@(posedge mclk) disable iff (rst)
    state_q == flir_pkg::ST_REQUEST && mode == flir_pkg::MODE_POS_INDEP
    && level == flir_pkg::LVL_6 && grant_chain_in && level_request_line_in[flir_pkg::LINE_L7]
    |=> grant_chain_out && !granted)
    else $error("Level 6 module kept grant over level 7 request.");

  l7_keeps_a: assert property (@(posedge mclk) disable iff (rst)
    state_q == flir_pkg::ST_REQUEST && mode == flir_pkg::MODE_POS_INDEP
    && level == flir_pkg::LVL_7 && grant_chain_in
    |=> granted && !grant_chain_out)
    else $error("Level 7 module passed grant.");

  idle_lines_a: assert property (@(posedge mclk) disable iff (rst)
    state_q == flir_pkg::ST_IDLE |-> level_request_line_out == flir_pkg::LINES_NONE)
    else $error("Request lines up while idle.");

  grant_cause_a: assert property (@(posedge mclk) disable iff (rst)
    grant_chain_out |-> $past(grant_chain_in))
    else $error("Grant passed without incoming grant.");

  grant_kept_c:  cover property (@(posedge mclk) disable iff (rst) granted);
  grant_fwd_c:   cover property (@(posedge mclk) disable iff (rst)
    state_q == flir_pkg::ST_REQUEST ##1 grant_chain_out);
  idle_pass_c:   cover property (@(posedge mclk) disable iff (rst)
    state_q == flir_pkg::ST_IDLE && grant_chain_in);
  dep_keep_c:    cover property (@(posedge mclk) disable iff (rst)
    mode == flir_pkg::MODE_POS_DEP && granted);
  service_end_c: cover property (@(posedge mclk) disable iff (rst)
    state_q == flir_pkg::ST_SERVICE && service_done);

endmodule // flir_request

/* File: sim/flir_cpu_model.sv */
// Processor-side model that issues the daisy-chained grant.
`timescale 1ns/1ns
module flir_cpu_model (
  // Clock and reset
  input  wire logic       mclk,
  input  wire logic       rst,
  // Bus side
  input  wire logic [3:0] bus_lines,
  input  wire logic       issue,
  output logic            grant_q,
  // Priority field of the processor status word
  input  wire logic [2:0] status_prio
);
  logic accept;

  // A request is taken only from a level above the priority in the status word.
  always_comb begin
    accept = (bus_lines[3] && status_prio < 3'h7) || (bus_lines[2] && status_prio < 3'h6)
          || (bus_lines[1] && status_prio < 3'h5) || (bus_lines[0] && status_prio < 3'h4);
  end

  // A grant only goes out in the cycle after issue was seen with an accepted request line up.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      grant_q <= 1'b0;
    end else begin
      grant_q <= issue & accept;
    end
  end
endmodule // flir_cpu_model

/* File: sim/testbench.sv */
// Self-checking testbench of the interrupt request block.
`timescale 1ns/1ns
module testbench;
  logic [1:0] level;
  logic [2:0] prio;
  logic [3:0] oth, lout;
  logic       mclk, rst, mode, irq, done, issue, gin, gout, gtd;
  int         fail_count, n_compared;

  flir_request i_dut (.mclk(mclk), .rst(rst), .level(level), .mode(mode), .irq_event(irq),
    .service_done(done), .granted(gtd), .level_request_line_in(lout | oth),
    .level_request_line_out(lout), .grant_chain_in(gin), .grant_chain_out(gout));
  flir_cpu_model i_cpu (.mclk(mclk), .rst(rst), .bus_lines(lout | oth), .issue(issue),
    .grant_q(gin), .status_prio(prio));

  task automatic chk(input logic [3:0] got, input logic [3:0] exp);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask

  task automatic request(input logic [1:0] l, input logic m, input logic [3:0] h);
    @(posedge mclk);
    level <= l; mode <= m; irq <= 1'b1; oth <= h;
    @(posedge mclk);
    irq <= 1'b0;
    tick(2);
  endtask

  task automatic grant();
    @(posedge mclk);
    issue <= 1'b1;
    @(posedge mclk);
    issue <= 1'b0;
    tick(1);
  endtask

  task automatic finish_req();
    @(posedge mclk);
    done <= 1'b1; oth <= 4'h0;
    @(posedge mclk);
    done <= 1'b0;
    tick(1);
  endtask

  task automatic test_masks();
    logic [3:0] m [4] = '{4'h1, 4'h3, 4'h5, 4'hd};
    for (int i = 0; i < 4; i++) begin
      request(2'(i), 1'b1, 4'h0);
      chk(lout, m[i]);
      grant();
      chk({2'h0, gtd, gout}, 4'h2);
      chk(lout, 4'h0);
      finish_req();
    end
    $display("test masks done");
  endtask

  task automatic test_monitor();
    logic [1:0] l [6] = '{2'h0, 2'h0, 2'h1, 2'h2, 2'h0, 2'h3};
    logic [3:0] h [6] = '{4'h2, 4'h4, 4'h4, 4'h8, 4'h8, 4'h6};
    logic [3:0] m [4] = '{4'h1, 4'h3, 4'h5, 4'hd};
    for (int i = 0; i < 6; i++) begin
      request(l[i], 1'b1, h[i]);
      grant();
      chk({2'h0, gtd, gout}, (i < 4) ? 4'h1 : 4'h2);
      chk(lout, (i < 4) ? m[l[i]] : 4'h0);
      @(posedge mclk);
      oth <= 4'h0;
      grant();
      chk({2'h0, gtd, gout}, (i < 4) ? 4'h2 : 4'h0);
      finish_req();
    end
    $display("test monitor done");
  endtask

  task automatic test_dep_idle();
    request(2'h1, 1'b0, 4'h8);
    chk(lout, 4'h2);
    grant();
    chk({2'h0, gtd, gout}, 4'h2);
    finish_req();
    @(posedge mclk);
    oth <= 4'h1;
    grant();
    chk({2'h0, gtd, gout}, 4'h1);
    finish_req();
    $display("test dep idle done");
  endtask

  task automatic test_prio();
    @(posedge mclk);
    prio <= 3'h5;
    request(2'h1, 1'b1, 4'h0);
    grant();
    chk({2'h0, gtd, gout}, 4'h0);
    chk(lout, 4'h3);
    @(posedge mclk);
    prio <= 3'h4;
    grant();
    chk({2'h0, gtd, gout}, 4'h2);
    finish_req();
    $display("test prio done");
  endtask

  task automatic end_sim();
    $display("compares %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  initial begin
    repeat (5000) @(posedge mclk);
    fail_count++;
    end_sim();
  end

  initial begin
    fail_count = 0; n_compared = 0; rst = 1'b1; level = 2'h0; mode = 1'b1;
    irq = 1'b0; done = 1'b0; issue = 1'b0; oth = 4'h0; prio = 3'h0;
    repeat (16) @(posedge mclk);
    rst <= 1'b0;
    test_masks();
    test_monitor();
    test_dep_idle();
    test_prio();
    end_sim();
  end
endmodule // testbench
